// ---- csp_port.sv ----
// Byte FIFO and transmit cell port with urgent request handshake.
// Assumes the upstream engine streams cell bytes on the reference clock.

module csp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Fill side.
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // Drain side.
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
    logic                full;
  } csp_fifo_st_t;

  csp_fifo_st_t st_r;
  csp_fifo_st_t st_nxt;
  logic         push;
  logic         pop;

  // Pointers wrap at the depth, which must be a power of two.
  always_comb begin
    st_nxt = st_r;
    push   = in_valid_i && !st_r.full;
    pop    = out_ready_i && (st_r.cnt != '0);
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data_i;
      st_nxt.wp           = st_r.wp + PTR_ONE;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + PTR_ONE;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + CNT_ONE;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - CNT_ONE;
    end
    st_nxt.full = (st_nxt.cnt == CNT_FULL);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready_o  = !st_r.full;
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = st_r.mem[st_r.rp];
endmodule : csp_fifo

module csp_port (
  // Clock and reset.
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_B_I,
  // Static mode pin, high selects ATM mode.
  input  wire logic       SEG_MODE_ATM_I,
  // Upstream cell source.
  input  wire logic       SEG_CELL_READY_I,
  input  wire logic [7:0] SEG_BYTE_I,
  input  wire logic       SEG_BYTE_VALID_I,
  output logic            SEG_BYTE_READY_O,
  output logic            SEG_URGENT_CELL_O,
  // Cell link.
  input  wire logic       TX_CELL_CLOCK_I,
  output logic            TX_CELL_CLOCK_O,
  output logic            TX_CELL_CLOCK_OE_O,
  input  wire logic       TX_CELL_ENABLE_I,
  output logic            TX_CELL_PRESENT_O,
  output logic [7:0]      TX_CELL_BYTE_O,
  output logic            TX_CELL_PARITY_O,
  output logic            TX_CELL_START_O,
  // Urgent segmentation handshake.
  input  wire logic       URGENT_SEG_REQUEST_I,
  output logic            URGENT_SEG_GRANT_O
);
  csp_pkg::csp_state_t st_r;
  csp_pkg::csp_state_t st_nxt;
  logic [7:0]          f_data;
  logic                f_valid;
  logic                pop;
  logic                tick;
  logic                grant_now;
  logic                go;
  logic                idle;

  // Byte buffer between the engine and the link.
  csp_fifo #(
    .W (csp_pkg::BYTE_W),
    .D (csp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (REF_CLK_I),
    .rst_b_i     (RST_B_I),
    .in_data_i   (SEG_BYTE_I),
    .in_valid_i  (SEG_BYTE_VALID_I),
    .in_ready_o  (SEG_BYTE_READY_O),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (pop)
  );

  // Next state: synchronisers, clocking, urgent handshake and byte flow.
  always_comb begin
    st_nxt         = st_r;
    st_nxt.s1_clk  = TX_CELL_CLOCK_I;
    st_nxt.s2_clk  = st_r.s1_clk;
    st_nxt.s3_clk  = st_r.s2_clk;
    st_nxt.s1_en   = TX_CELL_ENABLE_I;
    st_nxt.s2_en   = st_r.s1_en;
    st_nxt.s1_mode = SEG_MODE_ATM_I;
    st_nxt.s2_mode = st_r.s1_mode;
    st_nxt.s1_req  = URGENT_SEG_REQUEST_I;
    st_nxt.s2_req  = st_r.s1_req;
    st_nxt.grant   = 1'b0;
    idle           = (st_r.phase == csp_pkg::CSP_IDLE);
    // Divider makes the link clock in ATM mode; stopped in PHY mode.
    if (st_r.atm) begin
      st_nxt.div = st_r.div + 1'b1;
      if (st_r.div == csp_pkg::DIV_LAST) begin
        st_nxt.div     = '0;
        st_nxt.clk_out = !st_r.clk_out;
      end
    end else begin
      st_nxt.div     = '0;
      st_nxt.clk_out = 1'b0;
    end
    // PHY updates follow a partner rising edge; ATM updates at our falling edge.
    if (st_r.atm) begin
      tick = st_r.clk_out && (st_r.div == csp_pkg::DIV_LAST);
    end else begin
      tick = st_r.s2_clk && !st_r.s3_clk;
    end
    // Re-arm only once the request has been seen low again.
    if (!st_r.s2_req) begin
      st_nxt.req_armed = 1'b1;
    end
    // A segmentation opportunity is a link update between cells.
    grant_now = tick && idle && st_r.req_armed && st_r.s2_req;
    if (grant_now) begin
      st_nxt.grant     = 1'b1;
      st_nxt.req_armed = 1'b0;
      st_nxt.urgent    = 1'b1;
    end
    // Handshake decides whether a byte moves on this update.
    if (st_r.atm) begin
      go = st_r.s2_en && f_valid && (!idle || SEG_CELL_READY_I);
    end else begin
      go = !st_r.s2_en && f_valid && (!idle || st_r.link.present);
    end
    go  = go && tick && !grant_now;
    pop = go;
    if (go) begin
      st_nxt.link.data   = f_data;
      st_nxt.link.parity = csp_pkg::csp_odd_par(f_data);
      st_nxt.link.start  = (st_r.cnt == csp_pkg::CNT_FIRST);
      st_nxt.phase       = csp_pkg::CSP_CELL;
      st_nxt.cnt         = st_r.cnt + csp_pkg::CNT_STEP;
      if (st_r.cnt == csp_pkg::CNT_LAST) begin
        st_nxt.cnt    = csp_pkg::CNT_FIRST;
        st_nxt.phase  = csp_pkg::CSP_IDLE;
        st_nxt.urgent = 1'b0;
      end
    end else if (tick) begin
      st_nxt.link.start = 1'b0;
    end
    // Present pin: enable in ATM mode, cell-ready flag in PHY mode.
    if (tick) begin
      if (st_r.atm) begin
        st_nxt.link.present = !go;
      end else begin
        st_nxt.link.present = (st_nxt.phase == csp_pkg::CSP_IDLE)
                              && SEG_CELL_READY_I && !grant_now;
      end
    end
    // Mode is taken only between cells, never inside one.
    if (idle && !go && (st_r.atm != st_r.s2_mode)) begin
      st_nxt.atm          = st_r.s2_mode;
      st_nxt.link.present = st_r.s2_mode;
      st_nxt.link.start   = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output below is a flop of the state record.
  assign TX_CELL_CLOCK_O    = st_r.clk_out;
  assign TX_CELL_CLOCK_OE_O = st_r.atm;
  assign TX_CELL_PRESENT_O  = st_r.link.present;
  assign TX_CELL_BYTE_O     = st_r.link.data;
  assign TX_CELL_PARITY_O   = st_r.link.parity;
  assign TX_CELL_START_O    = st_r.link.start;
  assign URGENT_SEG_GRANT_O = st_r.grant;
  assign SEG_URGENT_CELL_O  = st_r.urgent;

  // Checks of the port behaviour.
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  sequence s_first_byte;
    TX_CELL_START_O && st_r.phase == csp_pkg::CSP_CELL;
  endsequence

  sequence s_byte_count_one;
    st_r.cnt == csp_pkg::CNT_STEP;
  endsequence

  a_parity_odd_out: assert property (
    (^{TX_CELL_BYTE_O, TX_CELL_PARITY_O}) == 1'b1 || !$past(RST_B_I) ||
    st_r.cnt == csp_pkg::CNT_FIRST && st_r.phase == csp_pkg::CSP_IDLE
  ) else $error("Parity is not odd over the byte.");

  a_start_first_byte: assert property (
    s_first_byte |-> s_byte_count_one
  ) else $error("Start flag not on the first byte.");

  a_grant_one_cycle: assert property (
    URGENT_SEG_GRANT_O |=> !URGENT_SEG_GRANT_O [*3]
  ) else $error("Grant longer than one cycle.");

  a_grant_has_cause: assert property (
    $rose(URGENT_SEG_GRANT_O) |-> $past(st_r.s2_req) && SEG_URGENT_CELL_O
  ) else $error("Grant without a sampled request.");

  a_atm_enable_valid: assert property (
    st_r.atm && $fell(TX_CELL_PRESENT_O) |-> $past(f_valid) && $past(st_r.s2_en)
  ) else $error("Enable low without a valid byte.");

  a_clock_half_period: assert property (
    st_r.atm && $rose(TX_CELL_CLOCK_O) |=> TX_CELL_CLOCK_O [*3]
  ) else $error("Link clock high time is wrong.");

  a_phy_clock_input: assert property (
    !st_r.atm |-> !TX_CELL_CLOCK_OE_O && !TX_CELL_CLOCK_O
  ) else $error("Clock driven in PHY mode.");

  a_mode_between_cells: assert property (
    $changed(st_r.atm) |-> $past(st_r.phase) == csp_pkg::CSP_IDLE
  ) else $error("Mode changed inside a cell.");

  a_cell_length_bound: assert property (
    st_r.cnt <= csp_pkg::CNT_LAST
  ) else $error("Byte count past the cell end.");

  a_phy_byte_follows: assert property (
    !st_r.atm && $changed(TX_CELL_START_O) && TX_CELL_START_O |->
      $past(!st_r.s2_en) && $past(tick)
  ) else $error("PHY byte without enable.");

  a_urgent_ends_cell: assert property (
    $fell(SEG_URGENT_CELL_O) |-> $past(st_r.cnt) == csp_pkg::CNT_LAST
  ) else $error("Urgent flag dropped mid-cell.");
endmodule : csp_port

// ---- csp_pkg.sv ----
// Constants and types of the cell segmentation port.
// Assumes one 200 MHz reference clock feeds every process.
// Behaviour
// - PHY mode: present high while a complete cell is ready.
// - ATM mode: present is a low-true enable, low only with a valid byte.
// - PHY mode: transfers follow the cell clock the partner drives.
// - ATM mode: cell clock is divided from the reference clock.
// - Data bus carries true data, bit 7 most significant.
// - PHY mode: low enable asks for a byte at the next clock.
// - ATM mode: high enable means the partner takes one more byte.
// - Parity output is odd parity over the eight data bits.
// - Start output high only with the first byte of a cell.
// - Urgent request is sampled at each new segmentation opportunity.
// - A seen urgent request makes the next cell come from channel one.
// - Grant is high for exactly one cycle per detected request.
package csp_pkg;
  localparam int          REF_PERIOD_NS  = 5;
  localparam int          LINK_PERIOD_NS = 40;
  localparam int          LINK_HALF_CYC  = (LINK_PERIOD_NS / 2) / REF_PERIOD_NS;
  localparam int          DIV_W          = $clog2(LINK_HALF_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(LINK_HALF_CYC - 1);
  localparam int          BYTE_W         = 8;
  localparam int          FIFO_DEPTH     = 16;
  localparam logic [5:0]  CNT_FIRST      = 6'h00;
  localparam logic [5:0]  CNT_LAST       = 6'h34;
  localparam logic [5:0]  CNT_STEP       = 6'h01;

  typedef enum logic {CSP_IDLE, CSP_CELL} csp_phase_t;

  // Link outputs, all registered.
  typedef struct packed {
    logic              present;
    logic [BYTE_W-1:0] data;
    logic              parity;
    logic              start;
  } csp_link_t;

  typedef struct packed {
    logic             s1_clk, s2_clk, s3_clk;
    logic             s1_en, s2_en;
    logic             s1_mode, s2_mode;
    logic             s1_req, s2_req;
    logic             atm;
    csp_phase_t       phase;
    logic [5:0]       cnt;
    logic [DIV_W-1:0] div;
    logic             clk_out;
    logic             req_armed;
    logic             urgent;
    logic             grant;
    csp_link_t        link;
  } csp_state_t;

  // Odd parity bit for one byte.
  function automatic logic csp_odd_par(input logic [BYTE_W-1:0] b);
    return ~(^b);
  endfunction : csp_odd_par
endpackage : csp_pkg

// ---- csp_partner.sv ----
// Behavioural far end of the cell link: ATM layer in PHY mode, PHY in ATM mode.
// Assumes the bench resolves the cell clock wire from the port's clock enable.
module csp_partner (
  // Link wires seen from the far end.
  input  wire logic       cell_clk_i,
  input  wire logic       atm_i,
  input  wire logic       slow_i,
  input  wire logic       present_i,
  input  wire logic       start_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       parity_i,
  // Wires the far end drives.
  output logic            clk_o,
  output logic            enable_o,
  // Last byte taken off the link.
  output logic [7:0]      byte_o,
  output logic            parity_o,
  output logic            start_o,
  output int              n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cnt;
  logic take;

  // Free running cell clock, used only while the port does not drive it.
  initial begin
    clk_o = 1'b0;
    forever #25 clk_o = ~clk_o;
  end

  // Initial levels: no read request and nothing captured.
  initial begin
    enable_o = 1'b1;
    n_o      = 0;
    cnt      = 0;
  end

  // Sample at the rising cell clock edge, then set the enable for the next cycle.
  always @(posedge cell_clk_i) begin
    take = atm_i ? !present_i : (!enable_o && (start_i || cnt != 0));
    if (take) begin
      byte_o   <= byte_i;
      parity_o <= parity_i;
      start_o  <= start_i;
      cnt = start_i ? 1 : cnt + 1;
      if (cnt == 53) cnt = 0;
      n_o <= n_o + 1;
    end
    // PHY reads with a low enable; ATM says it can take a byte with a high one.
    enable_o <= slow_i ? ~enable_o : atm_i;
  end
endmodule : csp_partner

// ---- csp_port_tb.sv ----
// Self-checking bench of the cell segmentation port.
// Assumes the partner model sits on the link and the bench feeds the byte FIFO.
module csp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_b, mode, cell_ready, valid, req, slow;
  logic [7:0] data;
  logic       ready_o, urgent_o, clk_o, clk_oe, present, par, sof, grant;
  logic [7:0] byte_o;
  logic       p_clk, p_en, g_par, g_sof;
  logic [7:0] g_byte;
  wire        cell_clk = clk_oe ? clk_o : p_clk;
  int         n_got, seen, pushed, target, fails, comparisons, k;

  csp_port csp_port_i (.REF_CLK_I(clk), .RST_B_I(rst_b), .SEG_MODE_ATM_I(mode),
    .SEG_CELL_READY_I(cell_ready), .SEG_BYTE_I(data), .SEG_BYTE_VALID_I(valid),
    .SEG_BYTE_READY_O(ready_o), .SEG_URGENT_CELL_O(urgent_o), .TX_CELL_CLOCK_I(cell_clk),
    .TX_CELL_CLOCK_O(clk_o), .TX_CELL_CLOCK_OE_O(clk_oe), .TX_CELL_ENABLE_I(p_en),
    .TX_CELL_PRESENT_O(present), .TX_CELL_BYTE_O(byte_o), .TX_CELL_PARITY_O(par),
    .TX_CELL_START_O(sof), .URGENT_SEG_REQUEST_I(req), .URGENT_SEG_GRANT_O(grant));

  csp_partner csp_partner_i (.cell_clk_i(cell_clk), .atm_i(clk_oe), .slow_i(slow),
    .present_i(present), .start_i(sof), .byte_i(byte_o), .parity_i(par), .clk_o(p_clk),
    .enable_o(p_en), .byte_o(g_byte), .parity_o(g_par), .start_o(g_sof), .n_o(n_got));

  // Reference clock, 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // Feeder pushes a counting byte sequence until the target is reached.
  always @(negedge clk) begin
    valid <= (pushed < target);
    data  <= pushed[7:0];
  end
  always @(posedge clk) if (valid && ready_o) pushed <= pushed + 1;

  // Each byte taken by the partner must follow the sequence.
  always @(negedge clk) if (n_got != seen) begin
    k = seen;
    seen++;
    check(16'(g_byte), 16'(k[7:0]));
    check(16'(g_par), 16'(~^k[7:0]));
    check(16'(g_sof), 16'(k % 53 == 0));
  end

  task automatic wait_bytes(input int n);
    for (int i = 0; i < 20000 && n_got < n; i++) @(negedge clk);
    check(16'(n_got), 16'(n));
  endtask : wait_bytes

  task automatic run_phy;
    target = 106;
    repeat (60) @(negedge clk);
    check(16'(ready_o), 16'h0000);
    check(16'(pushed), 16'h0010);
    cell_ready = 1'b1;
    for (int i = 0; i < 200 && present !== 1'b1; i++) @(negedge clk);
    check(16'(present), 16'h0001);
    check(16'(n_got), 16'h0000);
    wait_bytes(60);
    cell_ready = 1'b0;
    wait_bytes(106);
    repeat (20) @(negedge clk);
    check(16'(present), 16'h0000);
    check(16'(ready_o), 16'h0001);
  endtask : run_phy

  task automatic run_atm;
    int c;
    mode = 1'b1;
    slow = 1'b1;
    repeat (20) @(negedge clk);
    check(16'(clk_oe), 16'h0001);
    check(16'(present), 16'h0001);
    c = 0;
    @(posedge clk_o);
    @(negedge clk);
    for (int i = 0; i < 40 && clk_o !== 1'b0; i++) @(negedge clk);
    for (c = 0; c < 40 && clk_o !== 1'b1; c++) @(negedge clk);
    check(16'(c), 16'((csp_pkg::LINK_PERIOD_NS / 2) / csp_pkg::REF_PERIOD_NS));
    target = 212;
    cell_ready = 1'b1;
    wait_bytes(212);
    cell_ready = 1'b0;
  endtask : run_atm

  task automatic run_urgent;
    slow = 1'b0;
    repeat (20) @(negedge clk);
    req = 1'b1;
    for (int i = 0; i < 100 && grant !== 1'b1; i++) @(negedge clk);
    check(16'(grant), 16'h0001);
    check(16'(urgent_o), 16'h0001);
    req = 1'b0;
    @(negedge clk);
    check(16'(grant), 16'h0000);
    target = 265;
    cell_ready = 1'b1;
    wait_bytes(265);
    repeat (10) @(negedge clk);
    check(16'(urgent_o), 16'h0000);
  endtask : run_urgent

  // Main sequence: reset, then PHY, ATM and urgent scenarios.
  initial begin
    {rst_b, mode, cell_ready, req, slow} = 5'h00;
    {pushed, target, seen, fails, comparisons} = '0;
    valid = 1'b0;
    data  = 8'h00;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    check(16'({ready_o, present, clk_oe, grant}), 16'h0008);
    run_phy;
    run_atm;
    run_urgent;
    stop_test;
  end

  // Watchdog cuts a hang short.
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    stop_test;
  end
endmodule : csp_port_tb
